// ===== verilog/timer_ctl_pkg.sv
package timer_ctl_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] RUN_OFF     = 8'h04;
  localparam logic [7:0] CTRL_OFF    = 8'h08;
  localparam logic [7:0] MODE_OFF    = 8'h0C;
  localparam logic [7:0] UCAP_OFF    = 8'h1C;
  localparam logic [7:0] CMP0_OFF    = 8'h20;
  localparam logic [7:0] CMP1_OFF    = 8'h24;
  localparam logic [7:0] CAP0_OFF    = 8'h28;
  localparam logic [7:0] CAP1_OFF    = 8'h2C;
  // ==========================================================
  // Field positions
  localparam int RUN_BIT      = 0;
  localparam int PRUN_BIT     = 2;
  localparam int SSEL_BIT     = 0;
  localparam int TEDGE_BIT    = 1;
  localparam int IDLE_BIT     = 3;
  localparam int DBUF_BIT     = 7;
  localparam int CLKSEL_LSB   = 0;
  localparam int MCLR_BIT     = 3;
  localparam int CAPT_LSB     = 4;
  localparam int SCAP_BIT     = 6;
  localparam int PAIR_BIT     = 7;
  // ==========================================================
  // Reset values
  localparam logic [2:0] RUN_RST  = 3'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h8B;
  // Capture timing codes
  localparam logic [1:0] CAPT_OFF  = 2'h0;
  localparam logic [1:0] CAPT_PINR = 2'h1;
  localparam logic [1:0] CAPT_PINB = 2'h2;
  localparam logic [1:0] CAPT_PULS = 2'h3;
  localparam logic [2:0] CLK_PIN   = 3'h0;
  localparam int PRESC_W = 8;
endpackage : timer_ctl_pkg

// ===== verilog/pin_sync.sv
`timescale 1ns/1ns
// ==========================================================
// Three-stage synchroniser with agreement filter
module pin_sync (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // Pin
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1;
  logic s2;
  logic s3;
  // Shift chain
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Accept change once stages two and three agree
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) level_out <= 1'b0;
    else if (s2 == s3) level_out <= s3;
  end
endmodule : pin_sync

// ===== verilog/prescaler.sv
`timescale 1ns/1ns
// ==========================================================
// Free divider with tap select
module prescaler (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  // Tick
  output logic            tick_out
);
  logic [timer_ctl_pkg::PRESC_W-1:0] div;
  logic [timer_ctl_pkg::PRESC_W-1:0] mask;
  // Divider, stopped and cleared when not running
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) div <= '0;
    else if (!run_in) div <= '0;
    else div <= div + 8'h01;
  end
  // Tap masks: 1,4,16,32,64,128,256
  always_comb begin
    case (sel_in)
      3'h1:    mask = 8'h00;
      3'h2:    mask = 8'h03;
      3'h3:    mask = 8'h0F;
      3'h4:    mask = 8'h1F;
      3'h5:    mask = 8'h3F;
      3'h6:    mask = 8'h7F;
      3'h7:    mask = 8'hFF;
      default: mask = 8'h00;
    endcase
  end
  assign tick_out = run_in && ((div & mask) == mask);
endmodule : prescaler

// ===== verilog/timer_run_mode_control.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Start source bit 0 software/trigger; edge bit 1 rising/falling.
// - Counter capture read while stopped returns value caught while running.
// - Double buffer, paired bit 0: buffers load when counter clears on compare 1 match or wraps from FFFF.
// - Paired bit 1: load only after both compare registers written.
// - Control bit 3 stops timer in idle (0) or keeps running (1).
// - Writing 0 to soft capture copies counter to capture 0; reads 1.
// - Capture timing 00 off; 01 pin rising edge into capture 0.
// - Timing 10: pin rising into capture 0, falling into capture 1.
// - Timing 11: internal pulse rising into capture 0, falling capture 1.
// - Match clear enable clears counter on match with compare 1.
// - Clock select 000 pin, 001..111 prescaler taps 1 to 256.
module timer_run_mode_control (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // System and pins
  input  wire logic        unit_enable_in,
  input  wire logic        idle_mode_in,
  input  wire logic        external_capture_pin_in,
  input  wire logic        internal_capture_pulse_in,
  // Status
  output logic [15:0]      count_out,
  output logic             match1_out
);
  // ==========================================================
  // Registers
  logic [2:0]  run_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  mode_reg;
  logic [15:0] counter;
  logic [15:0] ucap;
  logic [15:0] cmp0_buf;
  logic [15:0] cmp1_buf;
  logic [15:0] cmp0;
  logic [15:0] cmp1;
  logic [15:0] cap0;
  logic [15:0] cap1;
  logic        wr0_seen;
  logic        wr1_seen;
  logic        started;
  logic        pin_lvl;
  logic        pin_q;
  logic        pls_q;
  // ==========================================================
  // Bus decode
  logic wr_en;
  logic addr_ok;
  assign wr_en = psel_in && penable_in && pwrite_in && unit_enable_in;
  assign addr_ok = (paddr_in == timer_ctl_pkg::RUN_OFF) || (paddr_in == timer_ctl_pkg::CTRL_OFF) ||
                   (paddr_in == timer_ctl_pkg::MODE_OFF) || (paddr_in == timer_ctl_pkg::UCAP_OFF) ||
                   (paddr_in == timer_ctl_pkg::CMP0_OFF) || (paddr_in == timer_ctl_pkg::CMP1_OFF) ||
                   (paddr_in == timer_ctl_pkg::CAP0_OFF) || (paddr_in == timer_ctl_pkg::CAP1_OFF);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && (!addr_ok || !unit_enable_in);
  logic wr_run;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cmp0;
  logic wr_cmp1;
  assign wr_run  = wr_en && (paddr_in == timer_ctl_pkg::RUN_OFF);
  assign wr_ctrl = wr_en && (paddr_in == timer_ctl_pkg::CTRL_OFF);
  assign wr_mode = wr_en && (paddr_in == timer_ctl_pkg::MODE_OFF);
  assign wr_cmp0 = wr_en && (paddr_in == timer_ctl_pkg::CMP0_OFF);
  assign wr_cmp1 = wr_en && (paddr_in == timer_ctl_pkg::CMP1_OFF);
  // ==========================================================
  // Field aliases
  logic       count_run;
  logic       prescale_run;
  logic       start_source_select;
  logic       trigger_edge_select;
  logic       idle_operate;
  logic       double_buffer_enable;
  logic       paired_rewrite_mode;
  logic [1:0] capture_timing;
  logic       match_clear_enable;
  logic [2:0] source_clock_select;
  assign count_run            = run_reg[timer_ctl_pkg::RUN_BIT];
  assign prescale_run         = run_reg[timer_ctl_pkg::PRUN_BIT];
  assign start_source_select  = ctrl_reg[timer_ctl_pkg::SSEL_BIT];
  assign trigger_edge_select  = ctrl_reg[timer_ctl_pkg::TEDGE_BIT];
  assign idle_operate         = ctrl_reg[timer_ctl_pkg::IDLE_BIT];
  assign double_buffer_enable = ctrl_reg[timer_ctl_pkg::DBUF_BIT];
  assign paired_rewrite_mode  = mode_reg[timer_ctl_pkg::PAIR_BIT];
  assign capture_timing       = mode_reg[timer_ctl_pkg::CAPT_LSB+:2];
  assign match_clear_enable   = mode_reg[timer_ctl_pkg::MCLR_BIT];
  assign source_clock_select  = mode_reg[timer_ctl_pkg::CLKSEL_LSB+:3];
  // Run and control registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_reg  <= timer_ctl_pkg::RUN_RST;
      ctrl_reg <= timer_ctl_pkg::CTRL_RST;
    end else begin
      if (wr_run) run_reg <= {pwdata_in[2], 1'b0, pwdata_in[0]};
      if (wr_ctrl) ctrl_reg <= pwdata_in[7:0] & timer_ctl_pkg::CTRL_WMASK;
    end
  end
  // Mode register; soft capture bit is not stored
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) mode_reg <= timer_ctl_pkg::MODE_RST;
    else if (wr_mode) mode_reg <= {pwdata_in[7], 1'b0, pwdata_in[5:0]};
  end
  // ==========================================================
  // Pin synchroniser and edge detection
  pin_sync u_pin_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (external_capture_pin_in),
    .level_out   (pin_lvl)
  );
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
      pls_q <= 1'b0;
    end else begin
      pin_q <= pin_lvl;
      pls_q <= internal_capture_pulse_in;
    end
  end
  logic pin_rise;
  logic pin_fall;
  logic pls_rise;
  logic pls_fall;
  assign pin_rise = pin_lvl && !pin_q;
  assign pin_fall = !pin_lvl && pin_q;
  assign pls_rise = internal_capture_pulse_in && !pls_q;
  assign pls_fall = !internal_capture_pulse_in && pls_q;
  // ==========================================================
  // Counting clock and start gate
  logic presc_tick;
  logic tick;
  logic trig_edge;
  logic active;
  prescaler u_prescaler (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .run_in      (prescale_run && count_run),
    .sel_in      (source_clock_select),
    .tick_out    (presc_tick)
  );
  assign tick = (source_clock_select == timer_ctl_pkg::CLK_PIN) ? pin_rise : presc_tick;
  assign trig_edge = trigger_edge_select ? pin_fall : pin_rise;
  assign active = count_run && prescale_run && (idle_operate || !idle_mode_in);
  // Start latch for external trigger start
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) started <= 1'b0;
    else if (!count_run) started <= 1'b0;
    else if (!start_source_select || trig_edge) started <= 1'b1;
  end
  logic counting;
  logic match1;
  assign counting = active && started;
  assign match1 = (counter == cmp1);
  // Up-counter
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) counter <= 16'h0000;
    else if (!count_run) counter <= 16'h0000;
    else if (counting && tick) begin
      if (match_clear_enable && match1) counter <= 16'h0000;
      else counter <= counter + 16'h0001;
    end
  end
  // Counter capture follows the counter only while running
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ucap <= 16'h0000;
    else if (count_run) ucap <= counter;
  end
  // ==========================================================
  // Compare buffers and double buffering
  logic load_pt;
  logic pair_xfer;
  assign load_pt = counting && tick && ((match_clear_enable && match1) || (counter == 16'hFFFF));
  assign pair_xfer = load_pt && wr0_seen && wr1_seen;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp0_buf <= 16'h0000;
      cmp1_buf <= 16'h0000;
    end else begin
      if (wr_cmp0) cmp0_buf <= pwdata_in[15:0];
      if (wr_cmp1) cmp1_buf <= pwdata_in[15:0];
    end
  end
  // Pair tracking: set wins over the clear at transfer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr0_seen <= 1'b0;
      wr1_seen <= 1'b0;
    end else begin
      if (wr_cmp0) wr0_seen <= 1'b1;
      else if (pair_xfer) wr0_seen <= 1'b0;
      if (wr_cmp1) wr1_seen <= 1'b1;
      else if (pair_xfer) wr1_seen <= 1'b0;
    end
  end
  // Active compare registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp0 <= 16'h0000;
      cmp1 <= 16'h0000;
    end else if (!double_buffer_enable) begin
      if (wr_cmp0) cmp0 <= pwdata_in[15:0];
      if (wr_cmp1) cmp1 <= pwdata_in[15:0];
    end else if (load_pt && (!paired_rewrite_mode || (wr0_seen && wr1_seen))) begin
      cmp0 <= cmp0_buf;
      cmp1 <= cmp1_buf;
    end
  end
  // ==========================================================
  // Capture registers
  logic soft_capture;
  logic cap0_ev;
  logic cap1_ev;
  assign soft_capture = wr_mode && !pwdata_in[timer_ctl_pkg::SCAP_BIT];
  assign cap0_ev = soft_capture ||
                   ((capture_timing == timer_ctl_pkg::CAPT_PINR) && pin_rise) ||
                   ((capture_timing == timer_ctl_pkg::CAPT_PINB) && pin_rise) ||
                   ((capture_timing == timer_ctl_pkg::CAPT_PULS) && pls_rise);
  assign cap1_ev = ((capture_timing == timer_ctl_pkg::CAPT_PINB) && pin_fall) ||
                   ((capture_timing == timer_ctl_pkg::CAPT_PULS) && pls_fall);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap0 <= 16'h0000;
      cap1 <= 16'h0000;
    end else begin
      if (cap0_ev) cap0 <= counter;
      if (cap1_ev) cap1 <= counter;
    end
  end
  // ==========================================================
  // Read data
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) prdata_out <= 32'h0000_0000;
    else if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        timer_ctl_pkg::RUN_OFF:  prdata_out <= {29'h0, run_reg};
        timer_ctl_pkg::CTRL_OFF: prdata_out <= {24'h0, ctrl_reg};
        timer_ctl_pkg::MODE_OFF: prdata_out <= {24'h0, mode_reg[7], 1'b1, mode_reg[5:0]};
        timer_ctl_pkg::UCAP_OFF: prdata_out <= {16'h0, ucap};
        timer_ctl_pkg::CMP0_OFF: prdata_out <= {16'h0, cmp0};
        timer_ctl_pkg::CMP1_OFF: prdata_out <= {16'h0, cmp1};
        timer_ctl_pkg::CAP0_OFF: prdata_out <= {16'h0, cap0};
        timer_ctl_pkg::CAP1_OFF: prdata_out <= {16'h0, cap1};
        default:                 prdata_out <= 32'h0000_0000;
      endcase
      if (!unit_enable_in) prdata_out <= 32'h0000_0000;
    end
  end
  // Status outputs
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out  <= 16'h0000;
      match1_out <= 1'b0;
    end else begin
      count_out  <= counter;
      match1_out <= match1 && counting;
    end
  end
  // ==========================================================
  // Assertions
  AST_STOP_CLEARS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !count_run |=> counter == 16'h0000) else $error("counter not cleared when stopped");
  AST_UCAP_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !count_run |=> $stable(ucap)) else $error("counter capture changed while stopped");
  AST_SOFT_CAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    soft_capture |=> cap0 == $past(counter)) else $error("soft capture missed");
  AST_CAPT_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (capture_timing == timer_ctl_pkg::CAPT_OFF) && !soft_capture |=> $stable(cap0) && $stable(cap1))
    else $error("capture while disabled");
  AST_PIN_FALL: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (capture_timing == timer_ctl_pkg::CAPT_PINB) && pin_fall |=> cap1 == $past(counter))
    else $error("pin falling capture missed");
  AST_PLS_RISE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (capture_timing == timer_ctl_pkg::CAPT_PULS) && pls_rise |=> cap0 == $past(counter))
    else $error("pulse rising capture missed");
  AST_MATCH_CLR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    counting && tick && match_clear_enable && match1 |=> counter == 16'h0000)
    else $error("match clear missed");
  AST_IDLE_STOP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    count_run && idle_mode_in && !idle_operate |=> $stable(counter)) else $error("counted in idle");
  AST_PAIR_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    double_buffer_enable && paired_rewrite_mode && !(wr0_seen && wr1_seen) |=> $stable(cmp0))
    else $error("paired transfer without both writes");
  AST_DBUF_LOAD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    double_buffer_enable && !paired_rewrite_mode && load_pt |=> cmp1 == $past(cmp1_buf))
    else $error("buffered compare not loaded");
endmodule : timer_run_mode_control

// ===== dv/apb_sw_model.sv
`timescale 1ns/1ns
// ==========================================================
// Software side: APB master, one transfer at a time
module apb_sw_model (
  // Clock
  input  wire logic        core_clk_in,
  // Answer
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  // Request
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out
);
  // Idle bus at time zero
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h00000000;
  end

  // Setup, access until ready, then release with data scrambled
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= wr;
    paddr_out   <= a;
    pwdata_out  <= wd;
    @(posedge core_clk_in);
    penable_out <= 1'b1;
    forever begin
      @(posedge core_clk_in);
      if (pready_in === 1'b1) break;
    end
    rd          = prdata_in;
    err         = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out  <= ~wd;
  endtask : xfer
endmodule : apb_sw_model

// ===== dv/timer_run_mode_control_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// Bench top
module timer_run_mode_control_tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        unit_en, idle, pin, pulse, match1, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] count, snap;
  int          failures, num_checks, cycles;
  int          sh [7]  = '{0, 2, 4, 5, 6, 7, 8};
  logic [15:0] c0e [4] = '{16'h0000, 16'h0002, 16'h0003, 16'h0005};
  logic [15:0] c1e [4] = '{16'h0000, 16'h0000, 16'h0004, 16'h0005};

  // Design and software model
  timer_run_mode_control u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .unit_enable_in(unit_en), .idle_mode_in(idle), .external_capture_pin_in(pin),
    .internal_capture_pulse_in(pulse), .count_out(count), .match1_out(match1));
  apb_sw_model u_sw (.core_clk_in(clk), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_sw.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic        e;
    u_sw.xfer(1'b0, a, 32'h00000000, r, e);
    chk(nm, r, exp);
  endtask : rdc

  // Full pin pulses, slow enough for the synchroniser
  task automatic edges(input int n);
    repeat (n) begin
      pin <= 1'b1;
      tick(8);
      pin <= 1'b0;
      tick(8);
    end
  endtask : edges

  task automatic end_sim;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    unit_en = 1'b1;
    idle = 1'b0;
    pin = 1'b0;
    pulse = 1'b0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    tick(16);
    rst_n <= 1'b1;
    // Reset values and writable bits
    rdc(timer_ctl_pkg::RUN_OFF, 32'h00000000, "run_rst");
    rdc(timer_ctl_pkg::CTRL_OFF, 32'h00000000, "ctrl_rst");
    rdc(timer_ctl_pkg::MODE_OFF, 32'h00000040, "mode_rst");
    wr(timer_ctl_pkg::RUN_OFF, 32'hFFFFFFFF);
    rdc(timer_ctl_pkg::RUN_OFF, 32'h00000005, "run_mask");
    wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
    wr(timer_ctl_pkg::CTRL_OFF, 32'hFFFFFFFF);
    rdc(timer_ctl_pkg::CTRL_OFF, 32'h0000008B, "ctrl_mask");
    wr(timer_ctl_pkg::MODE_OFF, 32'hFFFFFFFF);
    rdc(timer_ctl_pkg::MODE_OFF, 32'h000000FF, "mode_rw");
    wr(timer_ctl_pkg::CTRL_OFF, 32'h00000000);
    u_sw.xfer(1'b0, 8'h40, 32'h00000000, rdat, err);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_data", rdat, 32'h0);
    // Disabled unit refuses writes
    unit_en <= 1'b0;
    u_sw.xfer(1'b1, timer_ctl_pkg::CTRL_OFF, 32'h00000001, rdat, err);
    chk("disabled_err", 32'(err), 32'h1);
    unit_en <= 1'b1;
    rdc(timer_ctl_pkg::CTRL_OFF, 32'h00000000, "disabled_wr");
    // Pin clock with every capture timing code
    for (int k = 0; k < 4; k++) begin
      wr(timer_ctl_pkg::MODE_OFF, 32'(k << 4));
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      edges(k + 2);
      pulse <= 1'b1;
      tick(4);
      pulse <= 1'b0;
      tick(4);
      chk("pin_count", 32'(count), 32'(k + 2));
      rdc(timer_ctl_pkg::CAP0_OFF, 32'(c0e[k]), "cap0");
      rdc(timer_ctl_pkg::CAP1_OFF, 32'(c1e[k]), "cap1");
      wr(timer_ctl_pkg::MODE_OFF, 32'(k << 4));
      rdc(timer_ctl_pkg::CAP0_OFF, 32'(k + 2), "soft_cap");
      rdc(timer_ctl_pkg::UCAP_OFF, 32'(k + 2), "ucap_run");
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
      tick(4);
      chk("stop_clear", 32'(count), 32'h0);
      rdc(timer_ctl_pkg::UCAP_OFF, 32'(k + 2), "ucap_stop");
    end
    // Clear on compare 1 match, off and on
    for (int m = 0; m < 2; m++) begin
      wr(timer_ctl_pkg::CMP1_OFF, 32'h00000003);
      wr(timer_ctl_pkg::MODE_OFF, 32'(m << 3));
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      edges(3);
      chk("match1", 32'(match1), 32'h1);
      edges(1);
      chk("match_clear", 32'(count), (m == 1) ? 32'h0 : 32'h4);
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
    end
    // External trigger start, wrong edge then right edge
    for (int e = 0; e < 2; e++) begin
      wr(timer_ctl_pkg::CTRL_OFF, 32'(e * 2 + 1));
      wr(timer_ctl_pkg::MODE_OFF, 32'h00000001);
      pin <= (e == 0);
      tick(8);
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      pin <= (e == 1);
      tick(20);
      chk("trig_wrong", 32'(count), 32'h0);
      pin <= (e == 0);
      tick(20);
      chk("trig_right", 32'(count != 16'h0000), 32'h1);
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
      pin <= 1'b0;
      tick(8);
    end
    // Idle mode stops or keeps counting
    for (int i = 0; i < 2; i++) begin
      wr(timer_ctl_pkg::CTRL_OFF, 32'(i << 3));
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      idle <= 1'b1;
      tick(4);
      snap = count;
      tick(50);
      chk("idle_run", 32'(count != snap), 32'(i));
      idle <= 1'b0;
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
    end
    // Prescaler taps
    wr(timer_ctl_pkg::CTRL_OFF, 32'h00000000);
    for (int c = 1; c < 8; c++) begin
      wr(timer_ctl_pkg::MODE_OFF, 32'(c));
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      tick(1024);
      chk("presc_rate", 32'((int'(count) >= (1024 >> sh[c - 1]) - 3) &&
                            (int'(count) <= (1024 >> sh[c - 1]) + 3)), 32'h1);
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
    end
    // Double buffer, plain and paired rewrite
    for (int p = 0; p < 2; p++) begin
      wr(timer_ctl_pkg::CTRL_OFF, 32'h00000000);
      wr(timer_ctl_pkg::CMP1_OFF, 32'h00000003);
      wr(timer_ctl_pkg::CTRL_OFF, 32'h00000080);
      wr(timer_ctl_pkg::MODE_OFF, 32'(p * 128 + 8));
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000005);
      wr(timer_ctl_pkg::CMP1_OFF, 32'h00000005);
      edges(3);
      chk("db_old", 32'(match1), 32'h1);
      edges(4);
      chk("db_pair", 32'(match1), 32'(p));
      if (p == 1) begin
        wr(timer_ctl_pkg::CMP0_OFF, 32'h00000007);
        edges(1);
        rdc(timer_ctl_pkg::CMP1_OFF, 32'h00000005, "db_pair_cmp1");
        rdc(timer_ctl_pkg::CMP0_OFF, 32'h00000007, "db_pair_cmp0");
      end
      wr(timer_ctl_pkg::RUN_OFF, 32'h00000000);
    end
    end_sim();
  end
endmodule : timer_run_mode_control_tb_top
